/* inc/uart_rx_map.svh */
// constant map of the serial receiver: sample timing, frame entry layout, reset values
`ifndef UART_RX_MAP_SVH
`define UART_RX_MAP_SVH

// ----------------------------------------------------------------------------
// sampling
// ----------------------------------------------------------------------------
`define RX_SPB_NORMAL 5'h10
`define RX_SPB_DOUBLE 5'h08
`define RX_VOTE_NORMAL 5'h0A
`define RX_VOTE_DOUBLE 5'h06
`define RX_FIRST_SAMPLE 5'h01
`define RX_CNT_RST 5'h00
`define RX_IDLE_LINE 1'b1
`define RX_HIST_RST 2'h3

// ----------------------------------------------------------------------------
// character size: code 0 means five bits
// ----------------------------------------------------------------------------
`define RX_CHAR_MIN 4'h5
`define RX_CHAR_RST 4'h8
`define RX_IDX_RST 3'h0

// ----------------------------------------------------------------------------
// buffered frame entry: data, frame error, parity error, overrun
// ----------------------------------------------------------------------------
`define RX_DATA_W 8
`define RX_ENT_W 11
`define RX_ENT_FE 8
`define RX_ENT_PE 9
`define RX_ENT_DOR 10
`define RX_DATA_RST 8'h00

`endif

/* inc/uart_rx_pkg.sv */
// types shared by the serial receiver
package uart_rx_pkg;

   // ----------------------------------------------------------------------------
   // frame recovery states, one-hot
   // ----------------------------------------------------------------------------
   typedef enum logic [4:0]
   {
      RX_IDLE = 5'h01,
      RX_START = 5'h02,
      RX_DATA = 5'h04,
      RX_PARITY = 5'h08,
      RX_STOP = 5'h10
   } rx_state_t;

endpackage

/* verilog/majority3.sv */
// two-of-three majority voter for the centre samples of a bit
`timescale 1ns/1ps
module majority3
(
   input wire logic [2:0] samples, // three consecutive line samples
   output logic vote // level held by at least two samples
);

   assign vote = (samples[0] & samples[1]) | (samples[0] & samples[2]) |
      (samples[1] & samples[2]);

endmodule // majority3

/* verilog/rx_frame_buffer.sv */
// small receive fifo with valid/ready on both sides and a flush
`timescale 1ns/1ps
module rx_frame_buffer
#(
   parameter int WIDTH = 11,
   parameter int DEPTH = 2
)
(
   input wire logic clk_sys, // system clock
   input wire logic rst_b, // asynchronous reset, active low
   input wire logic flush, // empties the buffer, level
   input wire logic in_valid, // entry offered
   output logic in_ready, // room for an entry
   input wire logic [WIDTH-1:0] in_data, // entry to store
   output logic out_valid, // unread entry present
   input wire logic out_ready, // oldest entry consumed
   output logic [WIDTH-1:0] out_data // oldest entry
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   // ----------------------------------------------------------------------------
   // parameter check: pointers wrap by overflow
   // ----------------------------------------------------------------------------
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("rx_frame_buffer: DEPTH must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   assign in_ready = (count_reg != CW'(DEPTH)) & ~flush;
   assign out_valid = (count_reg != '0) & ~flush;
   assign out_data = mem_reg[rd_ptr_reg];
   assign count_next = flush ? '0 : CW'(count_reg + CW'(push) - CW'(pop));

   // ----------------------------------------------------------------------------
   // storage and pointers
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_reg[i] <= '0;
         end
      end
      else if (push)
      begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         wr_ptr_reg <= flush ? '0 : PW'(wr_ptr_reg + PW'(push));
         rd_ptr_reg <= flush ? '0 : PW'(rd_ptr_reg + PW'(pop));
         count_reg <= count_next;
      end
   end

endmodule // rx_frame_buffer

/* verilog/uart_receiver.sv */
// asynchronous serial receiver: start detection, frame recovery, status buffer
//
// Function
// - complete flag high exactly while buffer unread
// - disabling receiver flushes buffer, flag reads zero
// - interrupt requested while flag, enable, global set
// - error flags buffered per frame, read advances
// - error flags not writable, never interrupt
// - frame error equals zero first stop bit
// - only first stop bit checked, stop count ignored
// - overrun on start with full buffer, waiting char
// - overrun cleared when frame enters buffer
// - parity error reads zero when checking disabled
// - high mode bit enables checker, low picks odd
// - parity result buffered, valid until data read
// - disable is immediate, aborts frame, frees pin
// - sixteen samples per bit, eight in double speed
// - falling edge starts detection, first low sample one
// - start vote on samples 8-10 or 4-6
// - majority high rejects start as noise
// - valid start resynchronises bit timing every frame
// - first stop bit moves frame into buffer
`timescale 1ns/1ps
`include "uart_rx_map.svh"
module uart_receiver
#(
   parameter int DIV_W = 12,
   parameter int BUF_DEPTH = 2
)
(
   input wire logic clk_sys, // system clock, 125 MHz
   input wire logic rst_b, // asynchronous reset, active low
   input wire logic receiver_enable, // receiver on
   input wire logic double_speed, // eight samples per bit
   input wire logic parity_mode_high, // parity checker on
   input wire logic parity_mode_low, // odd parity when set
   input wire logic [1:0] char_size, // data bits minus five
   input wire logic [DIV_W-1:0] baud_divisor, // system clocks per sample minus one
   input wire logic serial_receive_pin, // receive line
   input wire logic data_read, // data register read strobe
   input wire logic receive_complete_int_enable, // receive interrupt enable
   input wire logic global_int_enable, // global interrupt enable
   output logic pin_override, // receiver owns the pin
   output logic receive_complete_flag, // unread data present
   output logic frame_error_flag, // oldest frame had bad stop bit
   output logic overrun_flag, // frames lost before oldest frame
   output logic parity_error_flag, // oldest frame had parity error
   output logic [7:0] rx_data, // oldest received character
   output logic rx_complete_irq // receive complete request
);

   // ----------------------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------------------
   if (DIV_W < 1 || BUF_DEPTH < 2)
   begin : g_bad_param
      $error("uart_receiver: DIV_W must be positive and BUF_DEPTH at least 2");
   end

   // ----------------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------------
   uart_rx_pkg::rx_state_t state_reg;
   uart_rx_pkg::rx_state_t state_next;
   logic [DIV_W-1:0] baud_cnt_reg;
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   logic [1:0] hist_reg;
   logic last_sample_reg;
   logic [2:0] bit_idx_reg;
   logic [3:0] nbits_reg;
   logic par_en_reg;
   logic par_odd_reg;
   logic par_err_reg;
   logic [7:0] shift_reg;
   logic pend_valid_reg;
   logic pend_valid_next;
   logic [7:0] pend_data_reg;
   logic pend_fe_reg;
   logic pend_pe_reg;
   logic ovr_reg;
   logic ovr_next;
   logic voted_bit;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [`RX_ENT_W-1:0] fifo_out_data;
   logic [`RX_ENT_W-1:0] fifo_in_data;

   // ----------------------------------------------------------------------------
   // sample clock and line history
   // ----------------------------------------------------------------------------
   wire sample_tick = (baud_cnt_reg == '0);
   wire [4:0] samples_per_bit = double_speed ? `RX_SPB_DOUBLE : `RX_SPB_NORMAL;
   wire [4:0] vote_sample = double_speed ? `RX_VOTE_DOUBLE : `RX_VOTE_NORMAL;
   wire in_idle = (state_reg == uart_rx_pkg::RX_IDLE);
   wire fall_seen = in_idle & sample_tick & receiver_enable & last_sample_reg &
      ~serial_receive_pin;
   // cnt_reg numbers the previous sample, so this tick takes sample cnt_reg + 1
   wire at_vote = ~in_idle & sample_tick & (5'(cnt_reg + 5'h01) == vote_sample);
   wire bit_end = cnt_reg == samples_per_bit;

   // the vote sees the two samples before this one plus the current sample
   majority3 u_vote
   (
      .samples({hist_reg, serial_receive_pin}),
      .vote(voted_bit)
   );

   // ----------------------------------------------------------------------------
   // recovery events
   // ----------------------------------------------------------------------------
   wire in_start = (state_reg == uart_rx_pkg::RX_START);
   wire in_data = (state_reg == uart_rx_pkg::RX_DATA);
   wire in_parity = (state_reg == uart_rx_pkg::RX_PARITY);
   wire in_stop = (state_reg == uart_rx_pkg::RX_STOP);
   wire start_ok = in_start & at_vote & ~voted_bit;
   wire data_vote = in_data & at_vote;
   wire last_bit = ({1'b0, bit_idx_reg} == 4'(nbits_reg - 4'h1));
   wire par_vote = in_parity & at_vote;
   // only the first stop bit is sampled; a second one is idle line to us
   wire stop_vote = in_stop & at_vote & receiver_enable;
   wire [3:0] nbits_sel = 4'(`RX_CHAR_MIN + {2'b00, char_size});
   wire parity_bad = (^shift_reg) ^ voted_bit ^ par_odd_reg;

   // overrun: both entries full and the shift register's character still waiting
   wire ovr_set = start_ok & receiver_enable & pend_valid_reg & ~fifo_in_ready;
   wire pend_accept = pend_valid_reg & fifo_in_ready;

   // ----------------------------------------------------------------------------
   // state machine
   // ----------------------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         uart_rx_pkg::RX_IDLE:
         begin
            if (fall_seen)
            begin
               state_next = uart_rx_pkg::RX_START;
            end
         end
         uart_rx_pkg::RX_START:
         begin
            if (at_vote)
            begin
               state_next = voted_bit ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_DATA;
            end
         end
         uart_rx_pkg::RX_DATA:
         begin
            if (at_vote && last_bit)
            begin
               state_next = par_en_reg ? uart_rx_pkg::RX_PARITY : uart_rx_pkg::RX_STOP;
            end
         end
         uart_rx_pkg::RX_PARITY:
         begin
            if (at_vote)
            begin
               state_next = uart_rx_pkg::RX_STOP;
            end
         end
         uart_rx_pkg::RX_STOP:
         begin
            if (at_vote)
            begin
               state_next = uart_rx_pkg::RX_IDLE;
            end
         end
         default:
         begin
            state_next = uart_rx_pkg::RX_IDLE;
         end
      endcase
      if (!receiver_enable)
      begin
         state_next = uart_rx_pkg::RX_IDLE;
      end
   end

   // sample counter restarts at the first low sample of every start bit
   assign cnt_next = fall_seen ? `RX_FIRST_SAMPLE :
      (in_idle || !sample_tick) ? cnt_reg :
      bit_end ? `RX_FIRST_SAMPLE : 5'(cnt_reg + 5'h01);

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= uart_rx_pkg::RX_IDLE;
         cnt_reg <= `RX_CNT_RST;
         baud_cnt_reg <= '0;
         hist_reg <= `RX_HIST_RST;
         last_sample_reg <= `RX_IDLE_LINE;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         baud_cnt_reg <= sample_tick ? baud_divisor : DIV_W'(baud_cnt_reg - 1'b1);
         if (sample_tick)
         begin
            hist_reg <= {hist_reg[0], serial_receive_pin};
            last_sample_reg <= serial_receive_pin;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // frame assembly; format is latched at the falling edge of the start bit
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         shift_reg <= `RX_DATA_RST;
         bit_idx_reg <= `RX_IDX_RST;
         nbits_reg <= `RX_CHAR_RST;
         par_en_reg <= 1'b0;
         par_odd_reg <= 1'b0;
         par_err_reg <= 1'b0;
      end
      else if (fall_seen)
      begin
         shift_reg <= `RX_DATA_RST;
         bit_idx_reg <= `RX_IDX_RST;
         nbits_reg <= nbits_sel;
         par_en_reg <= parity_mode_high;
         par_odd_reg <= parity_mode_low;
         par_err_reg <= 1'b0;
      end
      else if (data_vote)
      begin
         shift_reg[bit_idx_reg] <= voted_bit;
         bit_idx_reg <= 3'(bit_idx_reg + 3'h1);
      end
      else if (par_vote)
      begin
         par_err_reg <= parity_bad;
      end
   end

   // ----------------------------------------------------------------------------
   // completed frame waiting in the shift register stage
   // ----------------------------------------------------------------------------
   // a capture and the drop on overrun both outrank the hand-over to the buffer
   assign pend_valid_next = receiver_enable & (stop_vote |
      (pend_valid_reg & ~pend_accept & ~ovr_set));
   // the overrun mark is set at a start bit, cleared when a frame enters the buffer;
   // a set in the same cycle wins
   assign ovr_next = receiver_enable & (ovr_set | (ovr_reg & ~pend_accept));

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pend_valid_reg <= 1'b0;
         pend_data_reg <= `RX_DATA_RST;
         pend_fe_reg <= 1'b0;
         pend_pe_reg <= 1'b0;
         ovr_reg <= 1'b0;
      end
      else
      begin
         pend_valid_reg <= pend_valid_next;
         ovr_reg <= ovr_next;
         if (stop_vote)
         begin
            pend_data_reg <= shift_reg;
            pend_fe_reg <= ~voted_bit;
            pend_pe_reg <= par_en_reg & par_err_reg;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // receive buffer: each entry carries its character and its error bits
   // ----------------------------------------------------------------------------
   assign fifo_in_data = {ovr_reg, pend_pe_reg, pend_fe_reg, pend_data_reg};

   rx_frame_buffer
   #(
      .WIDTH(`RX_ENT_W),
      .DEPTH(BUF_DEPTH)
   )
   u_buffer
   (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .flush(~receiver_enable),
      .in_valid(pend_valid_reg),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(data_read),
      .out_data(fifo_out_data)
   );

   // ----------------------------------------------------------------------------
   // status toward the processor
   // ----------------------------------------------------------------------------
   // no write path reaches the error bits; they only come out of the buffer
   assign receive_complete_flag = fifo_out_valid;
   assign rx_data = fifo_out_data[`RX_DATA_W-1:0];
   assign frame_error_flag = fifo_out_valid & fifo_out_data[`RX_ENT_FE];
   assign overrun_flag = fifo_out_valid & fifo_out_data[`RX_ENT_DOR];
   assign parity_error_flag = fifo_out_valid & parity_mode_high &
      fifo_out_data[`RX_ENT_PE];
   // level request: it stays up until the buffer has been read empty
   assign rx_complete_irq = receive_complete_int_enable & global_int_enable &
      fifo_out_valid;
   assign pin_override = receiver_enable;

endmodule // uart_receiver

/* verification/serial_source.sv */
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module serial_source
(
   input wire logic clk_sys, // system clock
   output logic line // serial line, idle high
);
   // ----------------------
   // line driver
   // ----------------------
   initial line = 1'b1;

   // the line moves only just after an edge, so every sample sees a settled level
   task automatic hold(input logic level, input int clks);
      @(posedge clk_sys);
      line <= level;
      repeat (clks - 1) @(posedge clk_sys);
   endtask

   // start, data lsb first, optional parity, one stop; a low stop is a break-like fault
   task automatic send(input logic [7:0] d, input int n, input logic par_on,
      input logic par_bit, input logic stop_bit, input int clks);
      hold(1'b0, clks);
      for (int k = 0; k < n; k++)
         hold(d[k], clks);
      if (par_on)
         hold(par_bit, clks);
      hold(stop_bit, clks);
      if (!stop_bit)
         hold(1'b1, clks);
   endtask
endmodule // serial_source

/* verification/uart_receiver_properties.sv */
// assertion checker for the serial receiver status outputs
`timescale 1ns/1ps
module uart_receiver_checker
#(
   parameter int DIV_W = 12
)
(
   input wire logic clk_sys, // system clock
   input wire logic rst_b, // reset, active low
   input wire logic receiver_enable, // receiver on
   input wire logic double_speed, // eight samples per bit
   input wire logic parity_mode_high, // parity checker on
   input wire logic parity_mode_low, // odd parity
   input wire logic [1:0] char_size, // data bits minus five
   input wire logic [DIV_W-1:0] baud_divisor, // clocks per sample minus one
   input wire logic serial_receive_pin, // receive line
   input wire logic data_read, // data read strobe
   input wire logic receive_complete_int_enable, // interrupt enable
   input wire logic global_int_enable, // global enable
   input wire logic pin_override, // receiver owns pin
   input wire logic receive_complete_flag, // unread data
   input wire logic frame_error_flag, // bad stop bit
   input wire logic overrun_flag, // frames lost
   input wire logic parity_error_flag, // parity error
   input wire logic [7:0] rx_data, // oldest character
   input wire logic rx_complete_irq // interrupt request
);
   default clocking chk_cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   // ----------------------
   // sequences
   // ----------------------
   sequence enable_rise;
      $rose(receiver_enable);
   endsequence

   // no frame can finish within eight clocks of the receiver coming back
   sequence flag_quiet;
      !receive_complete_flag [*8];
   endsequence

   // ----------------------
   // properties
   // ----------------------
   irq_level_a:
      assert property (rx_complete_irq == (receive_complete_int_enable
         && global_int_enable && receive_complete_flag))
      else $error("interrupt request does not follow flag and enables");
   pin_owner_a:
      assert property (pin_override == receiver_enable)
      else $error("pin ownership differs from receiver enable");
   flush_gate_a:
      assert property (!receiver_enable |-> !receive_complete_flag)
      else $error("complete flag high while receiver off");
   enable_quiet_a:
      assert property (enable_rise |-> flag_quiet)
      else $error("stale entry after receiver re-enable");
   empty_errors_a:
      assert property (receiver_enable && !receive_complete_flag
         |-> !frame_error_flag && !overrun_flag && !parity_error_flag)
      else $error("error flag shown with empty buffer");
   parity_off_a:
      assert property (!parity_mode_high |-> !parity_error_flag)
      else $error("parity error with checker off");
   flag_fall_a:
      assert property ($fell(receive_complete_flag)
         |-> !receiver_enable || $past(data_read))
      else $error("complete flag fell without read or disable");
   entry_hold_a:
      assert property (receive_complete_flag && !data_read && receiver_enable
         |=> !receiver_enable || ($stable(rx_data) && $stable(frame_error_flag)
         && $stable(overrun_flag)))
      else $error("oldest entry changed without a read");
endmodule // uart_receiver_checker

bind uart_receiver uart_receiver_checker #(.DIV_W(DIV_W)) uart_receiver_checker_i
(
   .clk_sys(clk_sys), .rst_b(rst_b), .receiver_enable(receiver_enable),
   .double_speed(double_speed), .parity_mode_high(parity_mode_high),
   .parity_mode_low(parity_mode_low), .char_size(char_size), .baud_divisor(baud_divisor),
   .serial_receive_pin(serial_receive_pin), .data_read(data_read),
   .receive_complete_int_enable(receive_complete_int_enable),
   .global_int_enable(global_int_enable), .pin_override(pin_override),
   .receive_complete_flag(receive_complete_flag), .frame_error_flag(frame_error_flag),
   .overrun_flag(overrun_flag), .parity_error_flag(parity_error_flag),
   .rx_data(rx_data), .rx_complete_irq(rx_complete_irq)
);

/* verification/tb_top.sv */
// self-checking bench for the serial receiver
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'b0;
   logic rst_b, receiver_enable, double_speed, parity_mode_high, parity_mode_low;
   logic data_read, receive_complete_int_enable, global_int_enable, read_en;
   logic pin_override, receive_complete_flag, frame_error_flag, overrun_flag;
   logic parity_error_flag, rx_complete_irq, serial_receive_pin;
   logic [1:0] char_size;
   logic [11:0] baud_divisor;
   logic [7:0] rx_data;
   logic [31:0] b;
   logic [10:0] entry;
   logic [10:0] exp_q[$];
   int mismatches = 0;
   int checks_done = 0;
   integer seed = 32'hAA337DF1;

   always #4 clk_sys = ~clk_sys;
   assign entry = {overrun_flag, parity_error_flag, frame_error_flag, rx_data};

   uart_receiver uart_receiver_i
   (
      .clk_sys(clk_sys), .rst_b(rst_b), .receiver_enable(receiver_enable),
      .double_speed(double_speed), .parity_mode_high(parity_mode_high),
      .parity_mode_low(parity_mode_low), .char_size(char_size), .baud_divisor(baud_divisor),
      .serial_receive_pin(serial_receive_pin), .data_read(data_read),
      .receive_complete_int_enable(receive_complete_int_enable),
      .global_int_enable(global_int_enable), .pin_override(pin_override),
      .receive_complete_flag(receive_complete_flag), .frame_error_flag(frame_error_flag),
      .overrun_flag(overrun_flag), .parity_error_flag(parity_error_flag),
      .rx_data(rx_data), .rx_complete_irq(rx_complete_irq)
   );
   serial_source serial_source_i
   (
      .clk_sys(clk_sys),
      .line(serial_receive_pin)
   );

   // ----------------------
   // helpers
   // ----------------------
   task automatic compare(input logic [10:0] got, input logic [10:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // expectation is noted before the frame goes out, with the mode that is in force
   task automatic frame(input int keep, input logic bad, input logic stop_bit);
      logic [7:0] d;
      int n;
      @(negedge clk_sys);
      n = 5 + char_size;
      d = 8'($random(seed)) & (8'hFF >> (8 - n));
      if (keep > 0)
         exp_q.push_back({keep == 2, bad & parity_mode_high, ~stop_bit, d});
      serial_source_i.send(d, n, parity_mode_high, ^d ^ parity_mode_low ^ bad, stop_bit,
         (double_speed ? 8 : 16) * (baud_divisor + 1));
   endtask

   task automatic drain();
      for (int i = 0; i < 400 && (exp_q.size() != 0 || receive_complete_flag !== 1'b0); i++)
         @(negedge clk_sys);
      compare({receive_complete_flag, 10'(exp_q.size())}, 11'h000);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------
   // reader and watchdog
   // ----------------------
   always
   begin
      @(negedge clk_sys);
      if (read_en && receive_complete_flag === 1'b1)
      begin
         if (exp_q.size() == 0)
            compare(entry, {11{1'bx}});
         // status is only ever read here; no write reaches the error positions
         else
            compare(entry, exp_q.pop_front());
         @(posedge clk_sys);
         data_read <= 1'b1;
         @(posedge clk_sys);
         data_read <= 1'b0;
      end
   end

   initial
   begin
      repeat (60000) @(posedge clk_sys);
      mismatches++;
      stop_test();
   end

   // ----------------------
   // main sequence
   // ----------------------
   initial
   begin
      rst_b = 1'b0;
      receiver_enable = 1'b1;
      double_speed = 1'b0;
      parity_mode_high = 1'b0;
      parity_mode_low = 1'b0;
      char_size = 2'h3;
      baud_divisor = 12'h000;
      data_read = 1'b0;
      receive_complete_int_enable = 1'b0;
      global_int_enable = 1'b0;
      read_en = 1'b1;
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int m = 0; m < 32; m++)
      begin
         b = $random(seed);
         @(posedge clk_sys);
         {double_speed, parity_mode_high, parity_mode_low, char_size} <= m[4:0];
         baud_divisor <= {10'h000, b[1:0]};
         receive_complete_int_enable <= b[2];
         global_int_enable <= b[3];
         frame(1, b[4], b[5] | b[6]);
         drain();
      end
      // a low pulse that reaches only the first vote sample is noise in both speeds
      for (int s = 0; s < 2; s++)
      begin
         @(posedge clk_sys);
         double_speed <= s[0];
         baud_divisor <= 12'h001;
         @(posedge clk_sys);
         serial_source_i.hold(1'b0, s ? 8 : 16);
         serial_source_i.hold(1'b1, 64);
         // one more low sample reaches the vote: start taken, high line gives all ones
         exp_q.push_back(11'h0FF);
         serial_source_i.hold(1'b0, s ? 10 : 18);
         serial_source_i.hold(1'b1, s ? 200 : 400);
         frame(1, 1'b0, 1'b1);
         drain();
      end
      read_en <= 1'b0;
      frame(1, 1'b0, 1'b1);
      frame(1, 1'b0, 1'b1);
      frame(0, 1'b0, 1'b1);
      frame(2, 1'b0, 1'b1);
      read_en <= 1'b1;
      drain();
      frame(1, 1'b0, 1'b1);
      drain();
      read_en <= 1'b0;
      frame(0, 1'b0, 1'b1);
      fork
         frame(0, 1'b0, 1'b1);
         begin
            repeat (80) @(posedge clk_sys);
            receiver_enable <= 1'b0;
         end
      join
      @(negedge clk_sys);
      compare({9'h000, pin_override, receive_complete_flag}, 11'h000);
      @(posedge clk_sys);
      receiver_enable <= 1'b1;
      read_en <= 1'b1;
      frame(1, 1'b0, 1'b1);
      drain();
      stop_test();
   end
endmodule // tb_top
